// ---- design/timing_source_irq_status.sv ----
// Sticky interrupt status bytes [7:0] and [15:8] of a timing source.
// Assumes validity inputs and loop clock are asynchronous; mode is on clock.
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_cfg.svh"
// How it works
// [R1] Bit7 low sets on input three change
// [R2] Bit3 low sets on input two change
// [R3] Bit2 low sets on input one change
// [R4] Writing one clears; zero leaves flag
// [R5] Mid bit7 sets on operating mode change
// [R6] Mid bit6 on two missing cycles, locked
// [R7] Bytes reset to FF and 7F
// [R8] Mid bit0 sets on input four change
// [R9] Unused bits set only by reset; set beats clear
module timing_source_irq_status
  import irq_status_pkg::*;
#(
  parameter int MISS_LIMIT = 16   // Clocks without a loop edge that count one missing cycle
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Input clock monitors (asynchronous levels)
  input  wire logic                    ref_input_one_valid,
  input  wire logic                    ref_input_two_valid,
  input  wire logic                    ref_input_three_valid,
  input  wire logic                    ref_input_four_valid,
  // Mode state machine (same clock)
  input  wire irq_status_pkg::op_mode_t op_mode,
  input  wire logic                    free_run_or_holdover,
  // Primary loop reference (asynchronous)
  input  wire logic                    primary_loop_ref,
  // Register port
  input  wire logic                    low_wr,
  input  wire logic                    mid_wr,
  input  wire irq_status_pkg::status_byte_t wr_data,
  output var irq_status_pkg::status_byte_t low_status_q,
  output var irq_status_pkg::status_byte_t mid_status_q
);
  import irq_status_pkg::*;

  localparam int NSYNC = 5;   // Four validity levels plus loop reference

  // Whole-byte reset images; every position, used or not, starts from these
  localparam status_byte_t LOW_RESET_IMG = `LOW_RESET;
  localparam status_byte_t MID_RESET_IMG = `MID_RESET;

  // Synchroniser stages and previous levels
  logic [NSYNC-1:0] meta_q;   // First stage, read only by second
  logic [NSYNC-1:0] sync_q;   // Second stage
  logic [NSYNC-1:0] prev_q;   // Last synchronised level
  logic [NSYNC-1:0] change;   // Change pulses
  op_mode_t         mode_prev_q;
  logic             mode_seen_q;   // Mode history valid after first clock
  logic [1:0]       sync_arm_q;    // Validity history holds real pin levels
  logic [15:0]      gap_q;         // Clocks since last loop edge or missed cycle
  logic [1:0]       miss_q;        // Consecutive missing cycles
  logic             fail_pulse;
  logic             mode_pulse;
  logic [7:0]       low_clr;
  logic [7:0]       mid_clr;
  logic [7:0]       low_set;
  logic [7:0]       mid_set;
  logic [7:0]       low_flags;
  logic [7:0]       mid_flags;

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {primary_loop_ref, ref_input_four_valid, ref_input_three_valid,
                 ref_input_two_valid, ref_input_one_valid};
      sync_q <= meta_q;
    end
  end

  // Previous level and arming. The synchroniser resets to zero while the
  // pins usually idle high, so comparing too early would raise a false
  // change on release. Change detection waits until both sync_q and prev_q
  // carry sampled pin levels, which takes three edges after release.
  // Limitation: a validity change before the first edge after release is not reported.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q      <= '0;
      mode_prev_q <= '0;
      mode_seen_q <= 1'b0;
      sync_arm_q  <= 2'b00;
    end else begin
      prev_q      <= sync_q;
      mode_prev_q <= op_mode;
      mode_seen_q <= 1'b1;
      sync_arm_q  <= {sync_arm_q[0], mode_seen_q};
    end
  end

  // Either-direction changes of validity, only once the history is armed
  assign change     = sync_arm_q[1] ? (sync_q ^ prev_q) : '0;
  assign mode_pulse = mode_seen_q && (op_mode != mode_prev_q);   // [R5]

  // Missing-cycle detector: a gap of MISS_LIMIT clocks is one missed cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= '0;
      miss_q <= '0;
    end else if (change[4] || free_run_or_holdover) begin
      gap_q  <= '0;
      miss_q <= '0;
    end else if (gap_q >= 16'(MISS_LIMIT - 1)) begin
      gap_q <= '0;
      if (miss_q != 2'(`LOOP_MISS_COUNT)) begin
        miss_q <= miss_q + 2'd1;
      end
    end else begin
      gap_q <= gap_q + 16'd1;
    end
  end

  // Fail pulse on the second consecutive missed cycle, never in free-run or holdover
  assign fail_pulse = !free_run_or_holdover && !change[4]
                      && (gap_q >= 16'(MISS_LIMIT - 1))
                      && (miss_q == 2'(`LOOP_MISS_COUNT - 1));   // [R6]

  // Event routing into bit positions
  always_comb begin
    low_set = 8'h00;
    mid_set = 8'h00;
    low_set[`LOW_BIT_REF_THREE] = change[2];   // [R1]
    low_set[`LOW_BIT_REF_TWO]   = change[1];   // [R2]
    low_set[`LOW_BIT_REF_ONE]   = change[0];   // [R3]
    mid_set[`MID_BIT_MODE]      = mode_pulse;  // [R5]
    mid_set[`MID_BIT_LOOP_FAIL] = fail_pulse;  // [R6]
    mid_set[`MID_BIT_REF_FOUR]  = change[3];   // [R8]
  end

  // Write-one clear strobes
  assign low_clr = low_wr ? wr_data : 8'h00;   // [R4]
  assign mid_clr = mid_wr ? wr_data : 8'h00;   // [R4]

  // One sticky flag per bit position. Positions with no event source have
  // their set input held at zero by the routing above: after reset they show
  // the byte's reset image, and once written with one they read zero for good.
  for (genvar i = 0; i < 8; i++) begin : g_bits
    sticky_flag #(.RESET_VAL(LOW_RESET_IMG[i])) u_low (   // [R7]
      .clock       (clock),
      .rst_n       (rst_n),
      .set_pulse   (low_set[i]),   // [R9]
      .clear_pulse (low_clr[i]),
      .flag_q      (low_flags[i])
    );
    sticky_flag #(.RESET_VAL(MID_RESET_IMG[i])) u_mid (   // [R7]
      .clock       (clock),
      .rst_n       (rst_n),
      .set_pulse   (mid_set[i]),   // [R9]
      .clear_pulse (mid_clr[i]),
      .flag_q      (mid_flags[i])
    );
  end

  // Outputs straight from the flag flip-flops
  assign low_status_q = low_flags;
  assign mid_status_q = mid_flags;

  // Assertions
  property p_ref_one_sets;
    @(posedge clock) disable iff (!rst_n) change[0] |=> low_status_q[2];
  endproperty
  a_ref_one_sets: assert property (p_ref_one_sets) else $error("ref one flag not set"); // [R3]
  property p_ref_two_sets;
    @(posedge clock) disable iff (!rst_n) change[1] |=> low_status_q[3];
  endproperty
  a_ref_two_sets: assert property (p_ref_two_sets) else $error("ref two flag not set"); // [R2]
  property p_ref_three_sets;
    @(posedge clock) disable iff (!rst_n) change[2] |=> low_status_q[7];
  endproperty
  a_ref_three_sets: assert property (p_ref_three_sets) else $error("ref three flag"); // [R1]
  property p_ref_four_sets;
    @(posedge clock) disable iff (!rst_n) change[3] |=> mid_status_q[0];
  endproperty
  a_ref_four_sets: assert property (p_ref_four_sets) else $error("ref four flag"); // [R8]
  property p_mode_sets;
    @(posedge clock) disable iff (!rst_n)
      mode_seen_q && (op_mode != $past(op_mode)) |=> mid_status_q[7];
  endproperty
  a_mode_sets: assert property (p_mode_sets) else $error("mode flag not set"); // [R5]
  property p_no_fail_holdover;
    @(posedge clock) disable iff (!rst_n)
      free_run_or_holdover && !mid_status_q[6] |=> !mid_status_q[6];
  endproperty
  a_no_fail_holdover: assert property (p_no_fail_holdover) else $error("fail in holdover"); // [R6]
  property p_clear_one;
    @(posedge clock) disable iff (!rst_n)
      low_wr && wr_data[2] && !change[0] |=> !low_status_q[2];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("write one did not clear"); // [R4]
  property p_zero_keeps;
    @(posedge clock) disable iff (!rst_n)
      low_status_q[7] && !(low_wr && wr_data[7]) |=> low_status_q[7];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost without clear"); // [R4]
  // Positions with no event source may be cleared but must never come back
  property p_unused_zero;
    @(posedge clock) disable iff (!rst_n)
      ((low_status_q & ~`LOW_MASK) == 8'h00) && ((mid_status_q & ~`MID_MASK) == 8'h00)
      |=> ((low_status_q & ~`LOW_MASK) == 8'h00) && ((mid_status_q & ~`MID_MASK) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set"); // [R9]
  // A mode change on the very edge of its clearing write must survive
  property p_set_wins;
    @(posedge clock) disable iff (!rst_n)
      mode_pulse && mid_wr && wr_data[7] |=> mid_status_q[7];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set"); // [R9]
  // Main scenarios: loop failure, clearing write, validity change, set against clear
  c_fail: cover property (@(posedge clock) disable iff (!rst_n) fail_pulse);
  c_clear: cover property (@(posedge clock) disable iff (!rst_n) mid_wr && wr_data[7]);
  c_change: cover property (@(posedge clock) disable iff (!rst_n) change[2]);
  c_set_wins: cover property (@(posedge clock) disable iff (!rst_n) mode_pulse && mid_wr);
endmodule
`default_nettype wire

// ---- design/irq_status_cfg.svh ----
// Bit positions, reset values and masks of the interrupt status bytes.
// Assumes inclusion by bare name from design files.
`ifndef IRQ_STATUS_CFG_SVH
`define IRQ_STATUS_CFG_SVH
// Low byte flag positions
`define LOW_BIT_REF_THREE 7
`define LOW_BIT_REF_TWO   3
`define LOW_BIT_REF_ONE   2
// Mid byte flag positions
`define MID_BIT_MODE      7
`define MID_BIT_LOOP_FAIL 6
`define MID_BIT_REF_FOUR  0
// Reset values
`define LOW_RESET 8'hFF
`define MID_RESET 8'h7F
// Implemented bit masks
`define LOW_MASK 8'h8C
`define MID_MASK 8'hC1
// Missing cycles that declare loop reference failure
`define LOOP_MISS_COUNT 2
`endif

// ---- design/irq_status_pkg.sv ----
// Types shared by the interrupt status logic.
// Assumes nothing of its surroundings.
package irq_status_pkg;
  typedef logic [7:0] status_byte_t;   // One status byte
  typedef logic [2:0] op_mode_t;       // Operating mode code
endpackage

// ---- design/sticky_flag.sv ----
// One sticky flag: set by a pulse, cleared by a write-one strobe.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  // State
  output logic      flag_q
);
  // Set wins over clear so a coincident event is never lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RESET_VAL;
    end else if (set_pulse) begin
      flag_q <= 1'b1;   // [R9]
    end else if (clear_pulse) begin
      flag_q <= 1'b0;   // [R4]
    end
  end
endmodule
`default_nettype wire

// ---- sim/timing_source_irq_status_test.sv ----
// Self-checking bench for the sticky interrupt status bytes.
// Assumes the design package and config header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timing_source_irq_status_test;
  import irq_status_pkg::*;
  localparam int MISS = 4;            // Short gap limit keeps the run brief
  logic         clock, rst_n;         // Clock and reset
  logic         v1, v2, v3, v4;       // Validity levels
  logic         frh, loop_ref;        // Mode block and loop reference
  logic         loop_run;             // Loop reference toggler enable
  logic         low_wr, mid_wr;       // Write strobes
  op_mode_t     op_mode;              // Mode code
  status_byte_t wr_data, low_q, mid_q;
  int           n_mismatch, n_checks, cycles;
  typedef struct {int sel; status_byte_t lo; status_byte_t mi;} row_t;
  // One row per event source: which input moves, and the bytes it should give
  row_t rows[5] = '{'{0, 8'h04, 8'h00}, '{1, 8'h08, 8'h00}, '{2, 8'h80, 8'h00},
                    '{3, 8'h00, 8'h01}, '{4, 8'h00, 8'h80}};

  timing_source_irq_status #(.MISS_LIMIT(MISS)) uut (
    .clock(clock), .rst_n(rst_n), .ref_input_one_valid(v1), .ref_input_two_valid(v2),
    .ref_input_three_valid(v3), .ref_input_four_valid(v4), .op_mode(op_mode),
    .free_run_or_holdover(frh), .primary_loop_ref(loop_ref), .low_wr(low_wr),
    .mid_wr(mid_wr), .wr_data(wr_data), .low_status_q(low_q), .mid_status_q(mid_q));

  // Free-running clock, 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Loop reference edge every two clocks while enabled, well inside the gap limit
  initial begin
    forever begin
      repeat (2) @(posedge clock);
      #1;
      if (loop_run) loop_ref = ~loop_ref;
    end
  end

  // Hang guard: a ceiling far above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One-cycle write strobe to either or both bytes
  task automatic wr(input logic lo, input logic mi, input status_byte_t d);
    low_wr = lo;
    mid_wr = mi;
    wr_data = d;
    tick(1);
    low_wr = 1'b0;
    mid_wr = 1'b0;
    tick(1);   // A following write never re-raises a strobe in the same step
  endtask

  task automatic chk(input status_byte_t lo, input status_byte_t mi);
    n_checks++;
    if (low_q !== lo || mid_q !== mi) begin
      n_mismatch++;
      $display("MISMATCH t=%0t low=%h mid=%h expected %h %h", $time, low_q, mid_q, lo, mi);
    end
  endtask

  // Move one event source
  task automatic apply(input int sel);
    case (sel)
      0: v1 = ~v1;
      1: v2 = ~v2;
      2: v3 = ~v3;
      3: v4 = ~v4;
      default: op_mode = op_mode + 3'h1;
    endcase
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0; v1 = 1'b1; v2 = 1'b1; v3 = 1'b1; v4 = 1'b1;
    frh = 1'b1; loop_ref = 1'b0; loop_run = 1'b1; low_wr = 1'b0; mid_wr = 1'b0;
    wr_data = 8'h00; op_mode = 3'h0; n_mismatch = 0; n_checks = 0; cycles = 0;
    tick(5);
    chk(8'hFF, 8'h7F);
    rst_n = 1'b1;
    tick(2);
    frh = 1'b0;
    tick(4);
    chk(8'hFF, 8'h7F);
    wr(1'b1, 1'b1, 8'hFF);
    chk(8'h00, 8'h00);
    // Two passes: first each validity input goes invalid, then valid again, with one mode step in each pass
    repeat (2) foreach (rows[i]) begin
      apply(rows[i].sel);
      tick(6);
      chk(rows[i].lo, rows[i].mi);
      wr(1'b1, 1'b1, 8'hFF);
      chk(8'h00, 8'h00);
    end
    // Zeros and other bits (unused ones included) leave the flag alone
    apply(0);
    tick(6);
    wr(1'b1, 1'b1, 8'h00);
    chk(8'h04, 8'h00);
    wr(1'b1, 1'b0, 8'h7B);
    chk(8'h04, 8'h00);
    wr(1'b1, 1'b0, 8'h04);
    chk(8'h00, 8'h00);
    // A mode change landing on the clearing write keeps the flag
    apply(4);
    tick(2);
    apply(4);
    wr(1'b0, 1'b1, 8'h80);
    tick(2);
    chk(8'h00, 8'h80);
    wr(1'b0, 1'b1, 8'h80);
    chk(8'h00, 8'h00);
    // Loop reference stops while locked: flag within two gaps plus sync delay
    loop_run = 1'b0;
    tick(2 * MISS + 6);
    chk(8'h00, 8'h40);
    loop_run = 1'b1;
    tick(4);
    wr(1'b0, 1'b1, 8'h40);
    chk(8'h00, 8'h00);
    // Same stop in free-run or holdover raises nothing
    frh = 1'b1;
    loop_run = 1'b0;
    tick(6 * MISS);
    chk(8'h00, 8'h00);
    // Reset in mid-run restores the reset image
    apply(2);
    tick(6);
    rst_n = 1'b0;
    tick(1);
    chk(8'hFF, 8'h7F);
    rst_n = 1'b1;
    tick(1);
    chk(8'hFF, 8'h7F);
    // Clear at once; pins idle unlike the reset synchroniser must not set flags
    wr(1'b1, 1'b1, 8'hFF);
    tick(4);
    chk(8'h00, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
